// ---- mic_irq_ctrl.sv ----
// mic_irq_ctrl: request flags, enables, external pin edge detector,
// vectoring and return handling for an 8-bit microcontroller core.
// assumes the core sequencer runs on clk_sys_in, one clock per Q phase.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - global enable at bit 7 passes unmasked requests when set, blocks all when clear
// - every reset clears the global enable
// - each source has its own enable bit in control or peripheral enable registers
// - flags set on events regardless of any enable
// - taking an interrupt clears global enable, pushes return address, vectors to 0004h
// - return-from-interrupt pops stack into pc and sets global enable, two cycles
// - asynchronous pin events serviced three to four instruction cycles later
// - synchronous events enter the vector exactly three instruction cycles later
// - a request due next cycle after global enable clear stays pending
// - external pin edge triggered, option bit 6 selects rising or falling
// - selected edge sets external pin flag at control bit 1
// - clearing enable at control bit 4 stops the pin interrupting
// - enabled pin edge wakes core; vector only if global enable set
// - pin flag settable during Q4 to Q1, sampled every Q1
// - control register holds pin, port-change, timer0 flags, enables, global enable
// - peripheral flags in two request registers, enables at matching positions
module mic_irq_ctrl (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire mic_pkg::mic_bus_t bus_in,
    output logic [7:0] rdata_out,
    input wire mic_pkg::mic_events_t events_in,
    input wire logic ext_irq_pin_in,
    input wire mic_pkg::mic_core_t core_in,
    input wire logic [mic_pkg::MIC_PC_WIDTH-1:0] return_pc_in,
    input wire logic [mic_pkg::MIC_PC_WIDTH-1:0] stack_top_in,
    output logic [1:0] q_phase_out,
    output logic push_out,
    output logic pop_out,
    output logic load_pc_out,
    output logic [mic_pkg::MIC_PC_WIDTH-1:0] pc_value_out,
    output logic wake_out,
    output logic irq_out
);
    import mic_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] q;
        logic [7:0] ctrl;
        logic [7:0] peripheral_irq_enable_one;
        logic [7:0] peripheral_irq_enable_two;
        logic [7:0] peripheral_irq_request_one;
        logic [7:0] peripheral_irq_request_two;
        logic [7:0] option;
        logic pin_last;
        logic [1:0] lat_cnt;
        mic_state_t state;
        logic [7:0] rdata;
        logic push;
        logic pop;
        logic load_pc;
        logic [MIC_PC_WIDTH-1:0] pc_value;
        logic wake;
        logic irq;
    } mic_state_reg_t;

    mic_state_reg_t st;
    mic_state_reg_t next_st;

    logic edge_seen;
    logic any_request;
    logic take_ok;
    logic wr_ctrl;

    // ------------------------------------------------------------
    // combinational
    // ------------------------------------------------------------

    // edge detection on the pin; polarity from option bit
    always_comb begin
        if (st.option[MIC_BIT_EDGE_SEL]) begin
            edge_seen = ext_irq_pin_in & ~st.pin_last;
        end else begin
            edge_seen = ~ext_irq_pin_in & st.pin_last;
        end
    end

    // request qualification; peripheral group needs its own gate
    always_comb begin
        any_request = (st.ctrl[MIC_BIT_TIMER0_OVERFLOW_FLAG] & st.ctrl[MIC_BIT_T0IE])
            | (st.ctrl[MIC_BIT_EXTIF] & st.ctrl[MIC_BIT_EXTIE])
            | (st.ctrl[MIC_BIT_PCIF] & st.ctrl[MIC_BIT_PCIE])
            | (st.ctrl[MIC_BIT_PERIPHERAL_GROUP_ENABLE] & (|(st.peripheral_irq_request_one & st.peripheral_irq_enable_one) | |(st.peripheral_irq_request_two & st.peripheral_irq_enable_two)));
        // a core-side clear this cycle suppresses the take; request stays pending
        take_ok = st.ctrl[MIC_BIT_GIE] & ~core_in.gie_clear;
        wr_ctrl = bus_in.wr && bus_in.addr == MIC_ADDR_CORE_CTRL;
    end

    // main next-state logic
    always_comb begin
        next_st = st;
        next_st.q = st.q + 2'h1;
        // pin resampled only in Q4/Q1, so an edge arriving in Q2/Q3 is held off, not lost
        if (st.q == MIC_Q4 || st.q == MIC_Q1) begin
            next_st.pin_last = ext_irq_pin_in;
        end
        next_st.push = 1'b0;
        next_st.pop = 1'b0;
        next_st.load_pc = 1'b0;
        next_st.rdata = 8'h00;

        // software writes first; hardware events below win over clears
        if (bus_in.wr) begin
            unique case (bus_in.addr)
                MIC_ADDR_CORE_CTRL: next_st.ctrl = bus_in.wdata;
                MIC_ADDR_PERI_EN1: next_st.peripheral_irq_enable_one = bus_in.wdata & MIC_PERI1_MASK;
                MIC_ADDR_PERI_EN2: next_st.peripheral_irq_enable_two = bus_in.wdata & MIC_PERI2_MASK;
                MIC_ADDR_PERI_REQ1: next_st.peripheral_irq_request_one = bus_in.wdata & MIC_PERI1_MASK;
                MIC_ADDR_PERI_REQ2: next_st.peripheral_irq_request_two = bus_in.wdata & MIC_PERI2_MASK;
                MIC_ADDR_OPTION: next_st.option = bus_in.wdata;
                default: ;
            endcase
        end

        // pin flag set in Q4 or Q1 only, so the Q1 sample sees a stable value
        if (edge_seen && (st.q == MIC_Q4 || st.q == MIC_Q1)) begin
            next_st.ctrl[MIC_BIT_EXTIF] = 1'b1;
        end
        if (events_in.timer0_ovf) begin
            next_st.ctrl[MIC_BIT_TIMER0_OVERFLOW_FLAG] = 1'b1;
        end
        if (events_in.port_change) begin
            next_st.ctrl[MIC_BIT_PCIF] = 1'b1;
        end
        next_st.peripheral_irq_request_one = next_st.peripheral_irq_request_one | (events_in.peri1 & MIC_PERI1_MASK);
        next_st.peripheral_irq_request_two = next_st.peripheral_irq_request_two | (events_in.peri2 & MIC_PERI2_MASK);

        // core instruction clears the enable
        if (core_in.gie_clear) begin
            next_st.ctrl[MIC_BIT_GIE] = 1'b0;
        end

        unique case (st.state)
            MIC_IDLE: begin
                // requests are sampled at Q1; then two more whole cycles to the vector
                if (st.q == MIC_Q1 && any_request && take_ok && !core_in.return_from_irq_instr && !core_in.sleeping) begin
                    next_st.state = MIC_PENDING;
                    next_st.lat_cnt = MIC_LAT_LOAD;
                end else if (core_in.return_from_irq_instr && st.q == MIC_Q1) begin
                    next_st.state = MIC_RETURN;
                    next_st.lat_cnt = MIC_RET_LOAD;
                end
            end
            MIC_PENDING: begin
                if (st.q == MIC_Q4) begin
                    if (st.lat_cnt == 2'h0) begin
                        next_st.ctrl[MIC_BIT_GIE] = 1'b0;
                        next_st.push = 1'b1;
                        next_st.load_pc = 1'b1;
                        next_st.pc_value = MIC_VECTOR;
                        next_st.state = MIC_IDLE;
                    end else begin
                        next_st.lat_cnt = st.lat_cnt - 2'h1;
                    end
                end
            end
            MIC_RETURN: begin
                if (st.q == MIC_Q4) begin
                    if (st.lat_cnt == 2'h0) begin
                        next_st.pop = 1'b1;
                        next_st.load_pc = 1'b1;
                        next_st.pc_value = stack_top_in;
                        next_st.ctrl[MIC_BIT_GIE] = 1'b1;
                        next_st.state = MIC_IDLE;
                    end else begin
                        next_st.lat_cnt = st.lat_cnt - 2'h1;
                    end
                end
            end
            default: next_st.state = MIC_IDLE;
        endcase

        // wake ignores the global enable; core resumes next instruction or vectors
        next_st.wake = core_in.sleeping & any_request;
        next_st.irq = any_request & st.ctrl[MIC_BIT_GIE];

        // read data in the cycle after the strobe
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                MIC_ADDR_CORE_CTRL: next_st.rdata = st.ctrl;
                MIC_ADDR_PERI_EN1: next_st.rdata = st.peripheral_irq_enable_one;
                MIC_ADDR_PERI_EN2: next_st.rdata = st.peripheral_irq_enable_two;
                MIC_ADDR_PERI_REQ1: next_st.rdata = st.peripheral_irq_request_one;
                MIC_ADDR_PERI_REQ2: next_st.rdata = st.peripheral_irq_request_two;
                MIC_ADDR_OPTION: next_st.rdata = st.option;
                MIC_ADDR_STATUS: next_st.rdata = {6'h00, st.state};
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------

    // global enable comes out of reset cleared with everything else except option, which resets to all ones
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st <= '0;
            st.ctrl <= MIC_CTRL_RESET;
            st.option <= MIC_OPTION_RESET;
            st.state <= MIC_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_out = st.rdata;
    assign q_phase_out = st.q;
    assign push_out = st.push;
    assign pop_out = st.pop;
    assign load_pc_out = st.load_pc;
    assign pc_value_out = st.pc_value;
    assign wake_out = st.wake;
    assign irq_out = st.irq;

    // return address is held by the core's stack; push_out tells it to store return_pc_in
    logic unused_pc;
    assign unused_pc = ^return_pc_in ^ wr_ctrl;

endmodule // mic_irq_ctrl
`default_nettype wire

// ---- mic_pkg.sv ----
// mic_pkg: shared constants and carriers of the microcontroller interrupt controller.
// assumes one system clock; the quadrature phase counter lives in the controller itself.

package mic_pkg;

    // ------------------------------------------------------------
    // register indices on the plain register port
    // ------------------------------------------------------------
    localparam logic [2:0] MIC_ADDR_CORE_CTRL = 3'h0;
    localparam logic [2:0] MIC_ADDR_PERI_EN1 = 3'h1;
    localparam logic [2:0] MIC_ADDR_PERI_EN2 = 3'h2;
    localparam logic [2:0] MIC_ADDR_PERI_REQ1 = 3'h3;
    localparam logic [2:0] MIC_ADDR_PERI_REQ2 = 3'h4;
    localparam logic [2:0] MIC_ADDR_OPTION = 3'h5;
    localparam logic [2:0] MIC_ADDR_STATUS = 3'h6;

    // ------------------------------------------------------------
    // core_irq_control field positions, plus the option edge-select bit
    // ------------------------------------------------------------
    localparam int MIC_BIT_GIE = 7;
    localparam int MIC_BIT_PERIPHERAL_GROUP_ENABLE = 6;
    localparam int MIC_BIT_T0IE = 5;
    localparam int MIC_BIT_EXTIE = 4;
    localparam int MIC_BIT_PCIE = 3;
    localparam int MIC_BIT_TIMER0_OVERFLOW_FLAG = 2;
    localparam int MIC_BIT_EXTIF = 1;
    localparam int MIC_BIT_PCIF = 0;
    localparam int MIC_BIT_EDGE_SEL = 6;

    // ------------------------------------------------------------
    // reset values and implemented-bit masks
    // ------------------------------------------------------------
    localparam logic [7:0] MIC_CTRL_RESET = 8'h00;
    localparam logic [7:0] MIC_OPTION_RESET = 8'hFF;
    localparam logic [7:0] MIC_PERI1_MASK = 8'h7F;
    localparam logic [7:0] MIC_PERI2_MASK = 8'hFD;

    // ------------------------------------------------------------
    // vector and timing
    // ------------------------------------------------------------
    localparam logic [12:0] MIC_VECTOR = 13'h0004;
    localparam int MIC_PC_WIDTH = 13;
    localparam logic [1:0] MIC_Q1 = 2'h0;
    localparam logic [1:0] MIC_Q4 = 2'h3;
    localparam int MIC_SYNC_LATENCY_TCY = 3;
    localparam logic [1:0] MIC_LAT_LOAD = 2'(MIC_SYNC_LATENCY_TCY - 1);
    localparam int MIC_RETURN_FROM_IRQ_INSTR_TCY = 2;
    localparam logic [1:0] MIC_RET_LOAD = 2'(MIC_RETURN_FROM_IRQ_INSTR_TCY - 1);

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } mic_bus_t;

    typedef struct packed {
        logic timer0_ovf;
        logic port_change;
        logic [7:0] peri1;
        logic [7:0] peri2;
    } mic_events_t;

    typedef struct packed {
        logic return_from_irq_instr;
        logic gie_clear;
        logic sleeping;
    } mic_core_t;

    typedef enum logic [1:0] {
        MIC_IDLE,
        MIC_PENDING,
        MIC_RETURN
    } mic_state_t;

endpackage : mic_pkg

// ---- mic_irq_ctrl_assertions.sv ----
// mic_irq_ctrl_assertions: port checker for the interrupt controller.
// assumes one clock domain; bound onto every mic_irq_ctrl instance below.
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl_assertions (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire mic_pkg::mic_bus_t bus_in,
    input wire logic [7:0] rdata_out,
    input wire mic_pkg::mic_core_t core_in,
    input wire logic [mic_pkg::MIC_PC_WIDTH-1:0] stack_top_in,
    input wire logic [1:0] q_phase_out,
    input wire logic push_out,
    input wire logic pop_out,
    input wire logic load_pc_out,
    input wire logic [mic_pkg::MIC_PC_WIDTH-1:0] pc_value_out,
    input wire logic wake_out,
    input wire logic irq_out
);
    import mic_pkg::*;
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    vector_load_a: assert property (push_out |-> load_pc_out && pc_value_out == MIC_VECTOR)
        else $error("push without vector load");
    gie_drop_a: assert property (push_out |-> ##[1:2] !irq_out)
        else $error("request still raised after entry");
    return_load_a: assert property (pop_out |-> load_pc_out && pc_value_out == $past(stack_top_in))
        else $error("return did not load stack top");
    return_time_a: assert property (core_in.return_from_irq_instr && q_phase_out == MIC_Q1 |-> ##[1:9] pop_out)
        else $error("return not completed in two cycles");
    gie_clear_a: assert property (core_in.gie_clear |-> ##2 !irq_out)
        else $error("request survives enable clear");
    wake_cause_a: assert property (wake_out |-> $past(core_in.sleeping))
        else $error("wake while not sleeping");
    phase_step_a: assert property (!$past(rst_in) |-> q_phase_out == $past(q_phase_out) + 2'h1)
        else $error("phase counter skipped");
    read_idle_a: assert property (!$past(bus_in.rd) |-> rdata_out == 8'h00)
        else $error("read data outside read slot");
endmodule // mic_irq_ctrl_assertions
bind mic_irq_ctrl mic_irq_ctrl_assertions u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_in(bus_in),
    .rdata_out(rdata_out), .core_in(core_in), .stack_top_in(stack_top_in), .q_phase_out(q_phase_out),
    .push_out(push_out), .pop_out(pop_out), .load_pc_out(load_pc_out), .pc_value_out(pc_value_out),
    .wake_out(wake_out), .irq_out(irq_out));
`default_nettype wire

// ---- mic_core_model.sv ----
// mic_core_model: core sequencer stand-in with a program counter and a one-deep return stack.
// assumes push and load pulses come from the controller on the same clock.
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic push_in,
    input wire logic load_pc_in,
    input wire logic [12:0] pc_value_in,
    output logic [12:0] pc_out,
    output logic [12:0] stack_top_out
);
    // pc steps every clock unless loaded, so each push saves a distinct return address
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pc_out <= 13'h0100;
            stack_top_out <= 13'h0000;
        end else begin
            pc_out <= load_pc_in ? pc_value_in : pc_out + 13'h0001;
            if (push_in) stack_top_out <= pc_out;
        end
    end
endmodule // mic_core_model
`default_nettype wire

// ---- mic_irq_ctrl_tb_top.sv ----
// mic_irq_ctrl_tb_top: self-checking bench for the interrupt controller.
// assumes mic_pkg, the design, the checker and mic_core_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl_tb_top;
    import mic_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic pin = 1'b0;
    mic_bus_t bus = '0;
    mic_events_t evt = '0;
    mic_core_t core = '0;
    logic [12:0] pc, top, pcv;
    logic [13:0] seen;
    logic [7:0] rdata;
    logic [1:0] q;
    logic push, pop, load, wake, irq;
    int num_errors = 0;
    int checks_done = 0;
    int n;
    mic_irq_ctrl DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_in(bus), .rdata_out(rdata), .events_in(evt),
        .ext_irq_pin_in(pin), .core_in(core), .return_pc_in(pc), .stack_top_in(top), .q_phase_out(q),
        .push_out(push), .pop_out(pop), .load_pc_out(load), .pc_value_out(pcv), .wake_out(wake), .irq_out(irq));
    mic_core_model u_core (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .push_in(push), .load_pc_in(load),
        .pc_value_in(pcv), .pc_out(pc), .stack_top_out(top));
    // 50 MHz system clock
    initial begin
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    task automatic conclude;
        if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // bus cycles start and end on a rising edge, so strobes never collide
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys_in);
        bus <= '0;
        @(posedge clk_sys_in);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys_in);
        bus <= '0;
        @(negedge clk_sys_in);
        chk({8'h00, rdata}, {8'h00, e});
        @(posedge clk_sys_in);
    endtask
    task automatic pulse(input mic_events_t e);
        evt <= e;
        @(posedge clk_sys_in);
        evt <= '0;
    endtask
    // bounded wait on push (0), pop (1) or wake (2); a miss ends the run
    task automatic wait_on(input int sel, input int lim);
        logic s;
        n = 0;
        do begin
            @(negedge clk_sys_in);
            n++;
            s = sel == 0 ? push : sel == 1 ? pop : wake;
        end while (s !== 1'b1 && n < lim);
        seen = {load, pcv};
        chk({15'h0000, s}, 16'h0001);
        if (s !== 1'b1) conclude();
        @(posedge clk_sys_in);
    endtask
    task automatic quiet(input int lim);
        int hits;
        hits = 0;
        repeat (lim) begin
            @(negedge clk_sys_in);
            if (push === 1'b1) hits++;
        end
        chk(16'(hits), 16'h0000);
        @(posedge clk_sys_in);
    endtask
    // leaves the caller at the start of a Q1 cycle
    task automatic align;
        repeat (8) begin
            @(negedge clk_sys_in);
            if (q === MIC_Q4) break;
        end
        chk({14'h0000, q}, {14'h0000, MIC_Q4});
        @(posedge clk_sys_in);
    endtask
    task automatic t_flags;
        rd(MIC_ADDR_CORE_CTRL, 8'h00);
        rd(3'h7, 8'h00);
        pulse('{1'b1, 1'b1, 8'hFF, 8'hFF});
        rd(MIC_ADDR_CORE_CTRL, 8'h05);
        rd(MIC_ADDR_PERI_REQ1, 8'h7F);
        rd(MIC_ADDR_PERI_REQ2, 8'hFD);
        wr(MIC_ADDR_CORE_CTRL, 8'h00);
        wr(MIC_ADDR_PERI_REQ1, 8'h00);
        wr(MIC_ADDR_PERI_REQ2, 8'h00);
    endtask
    task automatic t_edge;
        for (int s = 0; s < 2; s++) begin
            wr(MIC_ADDR_OPTION, s[0] ? 8'hFF : 8'hBF);
            pin <= s[0];
            repeat (8) @(posedge clk_sys_in);
            wr(MIC_ADDR_CORE_CTRL, 8'h80);
            pin <= ~s[0];
            repeat (8) @(posedge clk_sys_in);
            rd(MIC_ADDR_CORE_CTRL, 8'h80);
            pin <= s[0];
            repeat (8) @(posedge clk_sys_in);
            rd(MIC_ADDR_CORE_CTRL, 8'h82);
            chk({15'h0000, irq}, 16'h0000);
            wr(MIC_ADDR_CORE_CTRL, 8'h00);
        end
    endtask
    // enabled pin edge in sleep with the global enable clear: wake, no vector
    task automatic t_sleep;
        wr(MIC_ADDR_CORE_CTRL, 8'h10);
        core <= '{1'b0, 1'b0, 1'b1};
        pin <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        pin <= 1'b1;
        wait_on(2, 12);
        quiet(16);
        core <= '0;
        // awake now: a pin edge with both enables set is serviced three to four cycles later
        wr(MIC_ADDR_CORE_CTRL, 8'h90);
        pin <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        pin <= 1'b1;
        wait_on(0, 20);
        chk(16'(n >= 4 * MIC_SYNC_LATENCY_TCY + 1 && n <= 17), 16'h0001);
        wr(MIC_ADDR_CORE_CTRL, 8'h00);
    endtask
    task automatic t_take;
        logic [12:0] ret;
        wr(MIC_ADDR_CORE_CTRL, 8'hA0);
        align();
        // event in Q4 so the flag is sampled at the very next Q1
        repeat (3) @(posedge clk_sys_in);
        pulse('{1'b1, 1'b0, 8'h00, 8'h00});
        wait_on(0, 20);
        chk(16'(n), 16'(4 * MIC_SYNC_LATENCY_TCY + 1));
        chk({2'b00, seen}, {3'b001, MIC_VECTOR});
        rd(MIC_ADDR_CORE_CTRL, 8'h24);
        ret = top;
        wr(MIC_ADDR_CORE_CTRL, 8'h20);
        align();
        core <= '{1'b1, 1'b0, 1'b0};
        @(posedge clk_sys_in);
        core <= '0;
        wait_on(1, 12);
        chk({2'b00, seen}, {3'b001, ret});
        chk(16'(n), 16'(4 * MIC_RETURN_FROM_IRQ_INSTR_TCY));
        rd(MIC_ADDR_CORE_CTRL, 8'hA0);
        wr(MIC_ADDR_CORE_CTRL, 8'h00);
    endtask
    // a request blocked by the global and group enables must stay pending
    task automatic t_gate;
        wr(MIC_ADDR_CORE_CTRL, 8'h08);
        pulse('{1'b0, 1'b1, 8'h00, 8'h00});
        quiet(16);
        // enable set in Q4, then the clearing instruction lands on the Q1 sample
        align();
        repeat (3) @(posedge clk_sys_in);
        bus <= '{MIC_ADDR_CORE_CTRL, 8'h89, 1'b1, 1'b0};
        @(posedge clk_sys_in);
        bus <= '0;
        core <= '{1'b0, 1'b1, 1'b0};
        @(posedge clk_sys_in);
        core <= '0;
        quiet(16);
        rd(MIC_ADDR_CORE_CTRL, 8'h09);
        wr(MIC_ADDR_CORE_CTRL, 8'h89);
        wait_on(0, 20);
        wr(MIC_ADDR_PERI_EN2, 8'h01);
        pulse('{1'b0, 1'b0, 8'h00, 8'h01});
        wr(MIC_ADDR_CORE_CTRL, 8'h80);
        quiet(16);
        wr(MIC_ADDR_CORE_CTRL, 8'hC0);
        wait_on(0, 20);
    endtask
    // reset, then each scenario in turn
    initial begin
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        t_flags();
        t_edge();
        t_sleep();
        t_take();
        t_gate();
        conclude();
    end
endmodule // mic_irq_ctrl_tb_top
`default_nettype wire
